// ==== hdl/prt_periodic_timer.sv ====
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module prt_periodic_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [prt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [prt_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [prt_pkg::DATA_W-1:0] rdata_o,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic sub_clock_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  output logic match_a_flag_o,
  output logic match_p_flag_o
);
  import prt_pkg::*;

  // ========================================================
  // registers
  logic pause_q;
  logic [2:0] cks_q;
  logic on_q;
  logic on_prev_q;
  logic [DATA_W-1:0] ctl1_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cmpa_q;
  logic [CNT_W-1:0] cmpp_q;
  logic [PRE_W-1:0] pre_q;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_f_q;
  logic lvl_q;
  logic lvl_d;
  logic on_d;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ========================================================
  // field decode
  wire [1:0] mode_w = ctl1_q[MODE_MSB:MODE_LSB];
  wire [1:0] pfs_w = ctl1_q[PFS_MSB:PFS_LSB];
  wire oc_w = ctl1_q[OC_BIT];
  wire inv_w = ctl1_q[INV_BIT];
  wire caps_w = ctl1_q[CAPS_BIT];
  wire cclr_w = ctl1_q[CCLR_BIT];
  wire cmp_like_w = (mode_w == MODE_CMP) || (mode_w == MODE_TMR);
  wire cmp_w = (mode_w == MODE_CMP);
  wire pwm_w = (mode_w == MODE_PWM);
  wire cap_w = (mode_w == MODE_CAP);
  wire sp_w = pwm_w && (pfs_w == PFS_PWM_SINGLE);

  // bus decode
  wire wr_ctl0_w = wr_i && (addr_i == ADDR_CTL0);
  wire wr_ctl1_w = wr_i && (addr_i == ADDR_CTL1);
  wire wr_al_w = wr_i && (addr_i == ADDR_CMPA_LO);
  wire wr_ah_w = wr_i && (addr_i == ADDR_CMPA_HI);
  wire wr_pl_w = wr_i && (addr_i == ADDR_CMPP_LO);
  wire wr_ph_w = wr_i && (addr_i == ADDR_CMPP_HI);

  // ========================================================
  // pin synchronisers, change accepted when stages two and three agree
  wire [NPIN-1:0] pin_raw_w = {sub_clock_i, capture_input_pin_i, external_clock_pin_i};
  wire [NPIN-1:0] pin_agree_w = ~(pin_s2_q ^ pin_s3_q);
  wire [NPIN-1:0] pin_f_d = (pin_s3_q & pin_agree_w) | (pin_f_q & ~pin_agree_w);
  wire [NPIN-1:0] pin_rise_w = pin_f_d & ~pin_f_q;
  wire [NPIN-1:0] pin_fall_w = ~pin_f_d & pin_f_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      pin_s3_q <= PIN_RST;
      pin_f_q <= PIN_RST;
    end else begin
      pin_s1_q <= pin_raw_w;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  // ========================================================
  // prescaler and counter clock selection
  wire pre4_w = (pre_q & PRE_DIV4) == PRE_DIV4;
  wire pre16_w = (pre_q & PRE_DIV16) == PRE_DIV16;
  wire pre64_w = (pre_q & PRE_DIV64) == PRE_DIV64;
  wire tick_w = (cks_q == CKS_SYS_DIV4) ? pre4_w :
                (cks_q == CKS_SYS) ? 1'b1 :
                (cks_q == CKS_HI_DIV16) ? pre16_w :
                (cks_q == CKS_HI_DIV64) ? pre64_w :
                (cks_q == CKS_SUB_A || cks_q == CKS_SUB_B) ? pin_rise_w[PIN_SUB] :
                (cks_q == CKS_EXT_RISE) ? pin_rise_w[PIN_EXT] :
                pin_fall_w[PIN_EXT];
  wire ext_act_w = (cks_q == CKS_EXT_FALL) ? pin_fall_w[PIN_EXT] : pin_rise_w[PIN_EXT];

  // free-running prescaler
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= PRE_RST;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // ========================================================
  // run control, matches and clear sources
  wire start_w = on_q && !on_prev_q; // on bit low-to-high
  wire run_w = on_q && !pause_q && !start_w;
  wire cnt_tick_w = run_w && tick_w;
  wire hit_a_w = cnt_tick_w && (cnt_q == cmpa_q);
  wire match_a_w = hit_a_w && !(cmp_like_w && (cmpa_q == CNT_RST));
  wire match_p_w = cnt_tick_w && (cnt_q == cmpp_q) && (cmpp_q != CNT_RST);
  wire pflag_w = match_p_w && !(cmp_like_w && cclr_w);
  // zero compare P lets the counter wrap through overflow
  wire clear_w = cmp_like_w ? (cclr_w ? match_a_w : match_p_w) :
                 pwm_w ? (match_p_w && !sp_w) : 1'b0;
  wire sp_trig_w = sp_w && !on_q && ext_act_w;
  wire sp_stop_w = sp_w && match_a_w;

  // on bit: pulse trigger sets, match A in single pulse clears
  assign on_d = sp_trig_w ? 1'b1 :
                sp_stop_w ? 1'b0 :
                wr_ctl0_w ? wdata_i[ON_BIT] : on_q;

  // counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (start_w) begin
      cnt_d = CNT_RST;
    end else if (clear_w) begin
      cnt_d = CNT_RST;
    end else if (cnt_tick_w) begin
      cnt_d = cnt_q + CNT_ONE;
    end
  end

  // control 0 and counter
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_q <= 1'b0;
      cks_q <= CKS_SYS_DIV4;
      on_q <= 1'b0;
      on_prev_q <= 1'b0;
      cnt_q <= CNT_RST;
    end else begin
      if (wr_ctl0_w) begin
        pause_q <= wdata_i[PAUSE_BIT];
        cks_q <= wdata_i[CKS_MSB:CKS_LSB];
      end
      on_q <= on_d;
      on_prev_q <= on_q;
      cnt_q <= cnt_d;
    end
  end

  AST_START_CLR: assert property ($rose(on_q) |=> cnt_q == CNT_RST)
    else $error("counter not zero after on rising");
  AST_OFF_FREEZE: assert property (!on_q |=> $stable(cnt_q))
    else $error("counter moved while off");
  AST_PAUSE_HOLD: assert property (on_q && on_prev_q && pause_q |=> $stable(cnt_q))
    else $error("counter moved while paused");
  AST_INC: assert property (cnt_tick_w && !clear_w |=> cnt_q == $past(cnt_q) + CNT_ONE)
    else $error("counter did not step by one");
  AST_OVF_WRAP: assert property (cmp_like_w && !cclr_w && cmpp_q == CNT_RST && cnt_tick_w
    && cnt_q == 16'hffff |=> cnt_q == CNT_RST)
    else $error("counter did not wrap on overflow");
  AST_A_CLEAR: assert property (cmp_like_w && cclr_w && match_a_w |=> cnt_q == CNT_RST)
    else $error("match A did not clear counter");
  AST_PWM_NO_A_CLR: assert property (pwm_w && !sp_w && cclr_w && hit_a_w && !match_p_w
    && cnt_q != 16'hffff |=> cnt_q != CNT_RST)
    else $error("clear select acted in PWM mode");

  // ========================================================
  // capture: edge of chosen source copies counter into compare A
  wire src_rise_w = caps_w ? pin_rise_w[PIN_EXT] : pin_rise_w[PIN_CAP];
  wire src_fall_w = caps_w ? pin_fall_w[PIN_EXT] : pin_fall_w[PIN_CAP];
  wire cap_evt_w = cap_w && on_q && (
                   ((pfs_w == PFS_CAP_RISE) && src_rise_w) ||
                   ((pfs_w == PFS_CAP_FALL) && src_fall_w) ||
                   ((pfs_w == PFS_CAP_BOTH) && (src_rise_w || src_fall_w)));

  // control 1 and compare registers, capture wins over a write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl1_q <= CTL_RST;
      cmpa_q <= CNT_RST;
      cmpp_q <= CNT_RST;
    end else begin
      if (wr_ctl1_w) begin
        ctl1_q <= wdata_i;
      end
      if (cap_evt_w) begin
        cmpa_q <= cnt_q;
      end else if (wr_al_w) begin
        cmpa_q[DATA_W-1:0] <= wdata_i;
      end else if (wr_ah_w) begin
        cmpa_q[CNT_W-1:DATA_W] <= wdata_i;
      end
      if (wr_pl_w) begin
        cmpp_q[DATA_W-1:0] <= wdata_i;
      end else if (wr_ph_w) begin
        cmpp_q[CNT_W-1:DATA_W] <= wdata_i;
      end
    end
  end

  AST_CAPTURE: assert property (cap_evt_w |=> cmpa_q == $past(cnt_q))
    else $error("capture did not load compare A");

  // ========================================================
  // output level before inversion
  wire pwm_lvl_w = (pfs_w == PFS_PWM_INACT) ? !oc_w :
                   (pfs_w == PFS_PWM_ACT) ? oc_w :
                   (pfs_w == PFS_PWM_WAVE) ? ((cnt_q < cmpa_q) ? oc_w : !oc_w) :
                   (on_q ? oc_w : !oc_w);
  wire cmp_lvl_w = (pfs_w == PFS_CMP_LOW) ? 1'b0 :
                   (pfs_w == PFS_CMP_HIGH) ? 1'b1 :
                   (pfs_w == PFS_CMP_TOGGLE) ? !lvl_q : lvl_q;

  always_comb begin
    lvl_d = lvl_q;
    if (start_w && (cmp_w || pwm_w)) begin
      lvl_d = oc_w;
    end else if (cmp_w && match_a_w) begin
      lvl_d = cmp_lvl_w;
    end else if (pwm_w) begin
      lvl_d = pwm_lvl_w;
    end
  end

  // level, pin and event outputs
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_q <= 1'b0;
      timer_output_pin_o <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
      match_a_flag_o <= 1'b0;
      match_p_flag_o <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      timer_output_pin_o <= (cmp_w || pwm_w) && (lvl_q ^ inv_w);
      timer_output_pin_oe_o <= cmp_w || pwm_w;
      match_a_flag_o <= match_a_w;
      match_p_flag_o <= pflag_w;
    end
  end

  AST_INIT_LVL: assert property (start_w && cmp_w |=> lvl_q == $past(oc_w))
    else $error("output not at initial level after start");
  AST_TOGGLE: assert property (cmp_w && !start_w && match_a_w && pfs_w == PFS_CMP_TOGGLE
    |=> lvl_q != $past(lvl_q))
    else $error("toggle did not flip output");
  AST_ONLY_A: assert property (cmp_w && !start_w && !match_a_w |=> $stable(lvl_q))
    else $error("compare output moved without match A");
  AST_PIN_INV: assert property (cmp_w ##1 cmp_w |-> timer_output_pin_o ==
    ($past(lvl_q) ^ $past(inv_w)))
    else $error("output pin polarity wrong");

  // ========================================================
  // read path, data valid only in the cycle after the strobe
  wire [DATA_W-1:0] ctl0_rd_w = {pause_q, cks_q, on_q, 3'h0};
  wire [DATA_W-1:0] rd_mux_w = (addr_i == ADDR_CTL0) ? ctl0_rd_w :
                               (addr_i == ADDR_CTL1) ? ctl1_q :
                               (addr_i == ADDR_CNT_LO) ? cnt_q[DATA_W-1:0] :
                               (addr_i == ADDR_CNT_HI) ? cnt_q[CNT_W-1:DATA_W] :
                               (addr_i == ADDR_CMPA_LO) ? cmpa_q[DATA_W-1:0] :
                               (addr_i == ADDR_CMPA_HI) ? cmpa_q[CNT_W-1:DATA_W] :
                               (addr_i == ADDR_CMPP_LO) ? cmpp_q[DATA_W-1:0] :
                               (addr_i == ADDR_CMPP_HI) ? cmpp_q[CNT_W-1:DATA_W] :
                               DATA_ZERO;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= DATA_ZERO;
    end else begin
      rdata_o <= rd_i ? rd_mux_w : DATA_ZERO;
    end
  end

  AST_RSV_ZERO: assert property (rd_i && addr_i == ADDR_CTL0 |=> rdata_o[RSV_MSB:0] == 3'h0)
    else $error("reserved control bits not zero");
  AST_CNT_READ: assert property (rd_i && addr_i == ADDR_CNT_HI
    |=> rdata_o == $past(cnt_q[CNT_W-1:DATA_W]))
    else $error("counter high byte read wrong");
endmodule : prt_periodic_timer

// ==== hdl/prt_pkg.sv ====
// ==========================================================
// shared constants for the periodic timer
package prt_pkg;
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 6;
  localparam int NPIN = 3;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTL1 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_CMPP_LO = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_CMPP_HI = 4'h7;

  // control 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CKS_MSB = 6;
  localparam int CKS_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int RSV_MSB = 2;

  // control 1 fields
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int PFS_MSB = 5;
  localparam int PFS_LSB = 4;
  localparam int OC_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int CAPS_BIT = 1;
  localparam int CCLR_BIT = 0;

  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // pin function codes per mode
  localparam logic [1:0] PFS_CMP_HOLD = 2'h0;
  localparam logic [1:0] PFS_CMP_LOW = 2'h1;
  localparam logic [1:0] PFS_CMP_HIGH = 2'h2;
  localparam logic [1:0] PFS_CMP_TOGGLE = 2'h3;
  localparam logic [1:0] PFS_PWM_INACT = 2'h0;
  localparam logic [1:0] PFS_PWM_ACT = 2'h1;
  localparam logic [1:0] PFS_PWM_WAVE = 2'h2;
  localparam logic [1:0] PFS_PWM_SINGLE = 2'h3;
  localparam logic [1:0] PFS_CAP_RISE = 2'h0;
  localparam logic [1:0] PFS_CAP_FALL = 2'h1;
  localparam logic [1:0] PFS_CAP_BOTH = 2'h2;

  // counter clock codes
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_HI_DIV16 = 3'h2;
  localparam logic [2:0] CKS_HI_DIV64 = 3'h3;
  localparam logic [2:0] CKS_SUB_A = 3'h4;
  localparam logic [2:0] CKS_SUB_B = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  // prescaler terminal masks
  localparam logic [PRE_W-1:0] PRE_DIV4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_DIV16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_DIV64 = 6'h3f;

  // pin slots in the synchroniser vector
  localparam int PIN_EXT = 0;
  localparam int PIN_CAP = 1;
  localparam int PIN_SUB = 2;

  // reset values and the counter step
  localparam logic [DATA_W-1:0] CTL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [NPIN-1:0] PIN_RST = 3'h0;
  localparam logic [PRE_W-1:0] PRE_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
endpackage : prt_pkg

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import prt_pkg::*;
  // ==========================================================
  // stimulus signals and counters
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic tog = 1'b0;
  logic ext_run = 1'b0;
  logic ext_lvl = 1'b0;
  logic cap_lvl = 1'b0;
  logic pin_o, pin_oe_o, flag_a, flag_p;
  int tcnt = 0;
  int error_cnt = 0;
  int checked = 0;
  wire logic ext_pin = ext_run ? tog : ext_lvl;

  // system clock, 40 ns period
  always #20 ref_clk_i = ~ref_clk_i;
  // slow source for sub and external clocks: period of 8 cycles
  always @(posedge ref_clk_i) begin
    tcnt <= tcnt + 1;
    if (tcnt % 4 == 3) tog <= ~tog;
  end

  prt_periodic_timer prt_periodic_timer_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_clock_pin_i(ext_pin),
    .capture_input_pin_i(cap_lvl), .sub_clock_i(tog), .timer_output_pin_o(pin_o),
    .timer_output_pin_oe_o(pin_oe_o), .match_a_flag_o(flag_a), .match_p_flag_o(flag_p)
  );

  // ==========================================================
  // shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    v = rdata_o; // data stand only in the cycle after the strobe
    @(posedge ref_clk_i);
  endtask : rd

  task rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask : rd16

  task wr16(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask : wr16

  // stop, set mode, restart; mode and pin function change only while off
  task start(input logic [7:0] c1);
    wr(ADDR_CTL0, 8'h10);
    wr(ADDR_CTL1, c1);
    wr(ADDR_CTL0, 8'h18);
  endtask : start

  task wait_flag(input bit p, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (((p ? flag_p : flag_a) !== 1'b1) && n < lim);
  endtask : wait_flag

  // ==========================================================
  // scenarios
  task t_regs;
    logic [7:0] v;
    logic [7:0] wd[9] = '{8'h67, 8'ha5, 8'h3c, 8'hc3, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
    logic [7:0] ex[9] = '{8'h60, 8'ha5, 8'h00, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00};
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], v);
      chk(v, 16'h0000);
    end
    for (int a = 0; a < 9; a++) wr(a[3:0], wd[a]);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], v);
      chk(v, ex[a]);
    end
    for (int a = 0; a < 8; a++) wr(a[3:0], 8'h00);
  endtask : t_regs

  task t_clock;
    logic [7:0] a, b, d, h;
    logic [15:0] v;
    int div[8] = '{4, 1, 16, 64, 8, 8, 8, 8};
    ext_run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTL0, {1'b0, c[2:0], 1'b1, 3'h0});
      repeat (8) @(posedge ref_clk_i);
      rd(ADDR_CNT_LO, a);
      repeat (div[c] * 10 - 2) @(posedge ref_clk_i);
      rd(ADDR_CNT_LO, b);
      d = b - a;
      chk(d, 16'h000a);
    end
    ext_run <= 1'b0;
    wr(ADDR_CTL0, 8'h98);
    rd(ADDR_CNT_LO, h);
    repeat (8) @(posedge ref_clk_i);
    rd(ADDR_CNT_LO, b);
    chk(b, h);
    wr(ADDR_CTL0, 8'h18);
    rd(ADDR_CNT_LO, a);
    d = a - h;
    chk(d <= 8'h08 && d != 8'h00, 1'b1);
    repeat (300) @(posedge ref_clk_i);
    wr(ADDR_CTL0, 8'h10);
    rd(ADDR_CNT_LO, a);
    repeat (8) @(posedge ref_clk_i);
    rd(ADDR_CNT_LO, b);
    chk(b, a);
    wr(ADDR_CTL0, 8'h18);
    rd16(ADDR_CNT_LO, v);
    chk(v < 16'h0010, 1'b1);
  endtask : t_clock

  task t_cmp;
    logic [1:0] pfs;
    logic oc, inv, e;
    int n;
    wr16(ADDR_CMPA_LO, 16'h0008);
    wr16(ADDR_CMPP_LO, 16'h000c);
    for (int i = 0; i < 16; i++) begin
      pfs = i[1:0];
      oc = i[2];
      inv = i[3];
      e = (pfs == PFS_CMP_HOLD) ? oc : (pfs == PFS_CMP_LOW) ? 1'b0 :
          (pfs == PFS_CMP_HIGH) ? 1'b1 : ~oc;
      start({MODE_CMP, pfs, oc, inv, 2'h0});
      repeat (3) @(posedge ref_clk_i);
      #1 chk({pin_oe_o, pin_o}, {1'b1, oc ^ inv});
      wait_flag(1'b0, 40, n);
      repeat (2) @(posedge ref_clk_i);
      #1 chk(pin_o, e ^ inv);
    end
    for (int cc = 0; cc < 2; cc++) begin
      start({MODE_CMP, PFS_CMP_TOGGLE, 3'h0, cc[0]});
      wait_flag(1'b0, 40, n);
      wait_flag(1'b0, 40, n);
      chk(n, cc ? 16'd9 : 16'd13);
      wait_flag(1'b1, 40, n);
      chk(n < 40, cc == 0);
    end
    start({MODE_PWM, PFS_PWM_WAVE, 4'h1});
    wait_flag(1'b1, 40, n);
    wait_flag(1'b1, 40, n);
    chk(n, 16'd13);
    for (int i = 0; i < 8; i++) begin
      start({MODE_PWM, 1'b0, i[0], i[1], i[2], 2'h0});
      repeat (4) @(posedge ref_clk_i);
      #1 chk({pin_oe_o, pin_o}, {1'b1, (i[0] ? i[1] : ~i[1]) ^ i[2]});
    end
    start({MODE_TMR, 6'h0c});
    wait_flag(1'b0, 40, n);
    chk({pin_oe_o, n < 40}, 2'h1);
  endtask : t_cmp

  task t_cap;
    logic [15:0] v;
    logic [1:0] pfs;
    for (int i = 0; i < 8; i++) begin
      pfs = i[1:0];
      start({MODE_CAP, pfs, 2'h0, i[2], 1'b0});
      wr16(ADDR_CMPA_LO, 16'h0000);
      if (i[2]) ext_lvl <= 1'b1;
      else cap_lvl <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      rd16(ADDR_CMPA_LO, v);
      chk(v != 16'h0000, pfs == PFS_CAP_RISE || pfs == PFS_CAP_BOTH);
      wr16(ADDR_CMPA_LO, 16'h0000);
      ext_lvl <= 1'b0;
      cap_lvl <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      rd16(ADDR_CMPA_LO, v);
      chk(v != 16'h0000, pfs == PFS_CAP_FALL || pfs == PFS_CAP_BOTH);
    end
  endtask : t_cap

  // single pulse: software start, match A ends it, then external pin trigger
  task t_sp;
    logic [7:0] v;
    int n;
    wr16(ADDR_CMPA_LO, 16'h0008);
    start({MODE_PWM, PFS_PWM_SINGLE, 4'h8});
    repeat (3) @(posedge ref_clk_i);
    #1 chk({pin_oe_o, pin_o}, 2'h3);
    wait_flag(1'b0, 40, n);
    chk(16'(n), 16'd6);
    repeat (2) @(posedge ref_clk_i);
    #1 chk(pin_o, 1'b0);
    rd(ADDR_CTL0, v);
    chk(v, 8'h10);
    ext_lvl <= 1'b1;
    wait_flag(1'b0, 40, n);
    chk(16'(n), 16'd14);
    ext_lvl <= 1'b0;
  endtask : t_sp

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_clock();
    t_cmp();
    t_cap();
    t_sp();
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge ref_clk_i);
    error_cnt++;
    $display("ERROR at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  end
endmodule : tb_top
